// >>> hdl/dpd_pkg.sv
package dpd_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] REG_CTRL0_IDX = 8'h00;
    localparam logic [7:0] REG_CTRL2_IDX = 8'h02;
    localparam logic [7:0] REG_SLEEP_IDX = 8'h04;
    localparam logic [7:0] REG_STATUS_IDX = 8'h05;

    // field positions
    localparam int CTRL0_AUTO_PD_BIT = 3;
    localparam int CTRL0_FULL_PD_BIT = 4;
    localparam int CTRL2_GATE_POL_BIT = 1;
    localparam int SLEEP_MAIN0_BIT = 0;
    localparam int SLEEP_MAIN1_BIT = 1;
    localparam int SLEEP_AUX0_BIT = 2;
    localparam int SLEEP_AUX1_BIT = 3;
    localparam int SLEEP_DIG_BIT = 4;

    // values after reset
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [7:0] SLEEP_RESET = 8'h00;

    // zero-flush length before automatic shutdown, in clk_sys cycles
    localparam int FLUSH_CYCLES = 16;
    localparam logic [4:0] FLUSH_LOAD = 5'(FLUSH_CYCLES - 1);

    localparam int SAMPLE_W = 16;

    typedef struct packed {
        logic [SAMPLE_W-1:0] chanI;
        logic [SAMPLE_W-1:0] chanQ;
    } dpd_sample_t;

    typedef struct packed {
        logic digitalEnable;
        logic referenceEnable;
        logic [1:0] mainConverterEnable;
        logic [1:0] auxConverterEnable;
    } dpd_power_t;

    typedef struct packed {
        logic wrStrobe;
        logic [7:0] wrIndex;
        logic [31:0] wrData;
    } dpd_write_t;

    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_FLUSH_HOLD = 4'b0010,
        ST_FLUSH_AUTO = 4'b0100,
        ST_DIG_OFF = 4'b1000
    } dpd_state_t;

endpackage : dpd_pkg

// >>> hdl/dpd_gate_sync.sv
`timescale 1ns/100ps
`default_nettype none
module dpd_gate_sync
    import dpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic asyncIn,
    output logic syncOut
);

    logic stage1Reg;
    logic stage2Reg;

    // stage1Reg feeds only stage2Reg
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stage1Reg <= 1'b0;
            stage2Reg <= 1'b0;
        end else begin
            stage1Reg <= asyncIn;
            stage2Reg <= stage1Reg;
        end
    end

    assign syncOut = stage2Reg;

endmodule : dpd_gate_sync
`default_nettype wire

// >>> hdl/dpd_ahb_slave.sv
`timescale 1ns/100ps
`default_nettype none
module dpd_ahb_slave
    import dpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output dpd_write_t wrPort,
    output logic [7:0] rdIndex,
    input wire logic [31:0] rdData
);

    logic phaseWriteReg;
    logic phaseValidReg;
    logic [7:0] phaseIndexReg;
    logic addrTaken;
    logic addrAligned;

    // only aligned word transfers land; anything else answers OKAY with no effect
    assign addrAligned = (haddr[1:0] == 2'b00) && (hsize == 3'b010) && (haddr[31:10] == 22'h0);
    assign addrTaken = hsel && htrans[1] && hready;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            phaseValidReg <= 1'b0;
            phaseWriteReg <= 1'b0;
            phaseIndexReg <= 8'h00;
        end else if (hready) begin
            phaseValidReg <= addrTaken && addrAligned;
            phaseWriteReg <= hwrite;
            phaseIndexReg <= haddr[9:2];
        end
    end

    // zero wait states: the slave never stalls the bus
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rdIndex = phaseIndexReg;
    assign hrdata = (phaseValidReg && !phaseWriteReg) ? rdData : 32'h0000_0000;
    assign wrPort.wrStrobe = phaseValidReg && phaseWriteReg;
    assign wrPort.wrIndex = phaseIndexReg;
    assign wrPort.wrData = hwdata;

endmodule : dpd_ahb_slave
`default_nettype wire

// >>> hdl/dpd_power_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module dpd_power_ctrl
    import dpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,

    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,

    input wire logic transmit_gate,

    input wire dpd_sample_t sampleIn,
    input wire logic sampleInValid,
    output dpd_sample_t sampleOut,
    output logic sampleOutValid,

    output dpd_power_t powerOut,
    output logic flushActive
);

    dpd_write_t wrPort;
    logic [7:0] rdIndex;
    logic [31:0] rdData;

    logic [7:0] ctrl0Reg;
    logic [7:0] ctrl2Reg;
    logic [7:0] sleepReg;

    logic gateSync;
    logic gateActive;
    logic autoPdEnable;
    logic fullPowerDown;
    logic digitalForcedOff;

    dpd_state_t stateReg;
    dpd_state_t stateNext;
    logic [4:0] flushCountReg;
    logic flushDone;

    dpd_power_t powerNext;
    dpd_power_t powerReg;
    logic engineRunning;

    function automatic logic isMapped(input logic [7:0] idx);
        isMapped = (idx == REG_CTRL0_IDX) || (idx == REG_CTRL2_IDX) ||
                   (idx == REG_SLEEP_IDX) || (idx == REG_STATUS_IDX);
    endfunction : isMapped

    function automatic logic writeHits(input dpd_write_t wr, input logic [7:0] idx);
        writeHits = wr.wrStrobe && (wr.wrIndex == idx);
    endfunction : writeHits

    // the control port sits outside every power gate, so it keeps working
    // even in full power-down
    dpd_ahb_slave u_ahb_slave (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wrPort(wrPort),
        .rdIndex(rdIndex),
        .rdData(rdData)
    );

    dpd_gate_sync u_gate_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .asyncIn(transmit_gate),
        .syncOut(gateSync)
    );

    // control register 0: full power-down and automatic shutdown enable
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl0Reg <= CTRL0_RESET;
        end else if (writeHits(wrPort, REG_CTRL0_IDX)) begin
            ctrl0Reg <= wrPort.wrData[7:0];
        end
    end

    // control register 2: gate polarity
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl2Reg <= CTRL2_RESET;
        end else if (writeHits(wrPort, REG_CTRL2_IDX)) begin
            ctrl2Reg <= wrPort.wrData[7:0];
        end
    end

    // sleep register: per-converter sleep and digital engine force-off
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sleepReg <= SLEEP_RESET;
        end else if (writeHits(wrPort, REG_SLEEP_IDX)) begin
            sleepReg <= {3'b000, wrPort.wrData[4:0]};
        end
    end

    assign autoPdEnable = ctrl0Reg[CTRL0_AUTO_PD_BIT];
    assign fullPowerDown = ctrl0Reg[CTRL0_FULL_PD_BIT];
    assign digitalForcedOff = sleepReg[SLEEP_DIG_BIT];

    // one xor serves every consumer of the gate, so no path sees the raw pin sense
    assign gateActive = gateSync ^ ctrl2Reg[CTRL2_GATE_POL_BIT];

    assign flushDone = (flushCountReg == 5'h00);

    always_comb begin
        stateNext = stateReg;
        unique case (stateReg)
            ST_RUN: begin
                if (!gateActive) begin
                    stateNext = autoPdEnable ? ST_FLUSH_AUTO : ST_FLUSH_HOLD;
                end
            end
            ST_FLUSH_HOLD: begin
                if (gateActive) begin
                    stateNext = ST_RUN;
                end else if (autoPdEnable) begin
                    stateNext = ST_FLUSH_AUTO;
                end
            end
            ST_FLUSH_AUTO: begin
                if (gateActive) begin
                    stateNext = ST_RUN;
                end else if (!autoPdEnable) begin
                    stateNext = ST_FLUSH_HOLD;
                end else if (flushDone) begin
                    stateNext = ST_DIG_OFF;
                end
            end
            ST_DIG_OFF: begin
                if (gateActive) begin
                    stateNext = ST_RUN;
                end else if (!autoPdEnable) begin
                    stateNext = ST_FLUSH_HOLD;
                end
            end
            default: begin
                stateNext = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stateReg <= ST_RUN;
        end else begin
            stateReg <= stateNext;
        end
    end

    // flush length counter, reloaded on every entry to the timed flush
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            flushCountReg <= FLUSH_LOAD;
        end else if (stateReg != ST_FLUSH_AUTO) begin
            flushCountReg <= FLUSH_LOAD;
        end else if (!flushDone) begin
            flushCountReg <= flushCountReg - 5'h01;
        end
    end

    // each converter and the digital engine are gated on their own; the reference drops only in full power-down
    always_comb begin
        powerNext.digitalEnable = !fullPowerDown && !digitalForcedOff &&
                                  (stateReg != ST_DIG_OFF);
        powerNext.referenceEnable = !fullPowerDown;
        powerNext.mainConverterEnable[0] = !fullPowerDown && !sleepReg[SLEEP_MAIN0_BIT];
        powerNext.mainConverterEnable[1] = !fullPowerDown && !sleepReg[SLEEP_MAIN1_BIT];
        powerNext.auxConverterEnable[0] = !fullPowerDown && !sleepReg[SLEEP_AUX0_BIT];
        powerNext.auxConverterEnable[1] = !fullPowerDown && !sleepReg[SLEEP_AUX1_BIT];
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            powerReg <= '0;
        end else begin
            powerReg <= powerNext;
        end
    end

    assign powerOut = powerReg;
    assign engineRunning = !fullPowerDown && !digitalForcedOff;

    // datapath: zeros during a flush, nothing while the engine is off
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sampleOut <= '0;
            sampleOutValid <= 1'b0;
        end else if (!engineRunning || stateReg == ST_DIG_OFF) begin
            sampleOut <= '0;
            sampleOutValid <= 1'b0;
        end else if (stateReg == ST_RUN) begin
            sampleOut <= sampleIn;
            sampleOutValid <= sampleInValid;
        end else begin
            sampleOut <= '0;
            sampleOutValid <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            flushActive <= 1'b0;
        end else begin
            // follows the registered state so it lines up with the zeros on sampleOut
            flushActive <= engineRunning &&
                           (stateReg == ST_FLUSH_HOLD || stateReg == ST_FLUSH_AUTO);
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        rdData = 32'h0000_0000;
        if (isMapped(rdIndex)) begin
            unique case (rdIndex)
                REG_CTRL0_IDX: rdData = {24'h00_0000, ctrl0Reg};
                REG_CTRL2_IDX: rdData = {24'h00_0000, ctrl2Reg};
                REG_SLEEP_IDX: rdData = {24'h00_0000, sleepReg};
                REG_STATUS_IDX: rdData = {24'h00_0000, stateReg, 1'b0,
                                          powerReg.referenceEnable,
                                          powerReg.digitalEnable, gateActive};
                default: rdData = 32'h0000_0000;
            endcase
        end
    end

endmodule : dpd_power_ctrl
`default_nettype wire

// >>> dv/dpd_power_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dpd_power_ctrl_monitor
    import dpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire dpd_sample_t sampleIn,
    input wire dpd_sample_t sampleOut,
    input wire logic sampleOutValid,
    input wire dpd_power_t powerOut,
    input wire logic flushActive
);
    logic wrCtrl0Reg;
    logic wrSleepReg;
    logic [5:0] flushCntReg;
    logic takeWr;
    assign takeWr = hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wrCtrl0Reg <= 1'b0;
            wrSleepReg <= 1'b0;
        end else begin
            wrCtrl0Reg <= takeWr && haddr == 32'h0000_0000;
            wrSleepReg <= takeWr && haddr == 32'h0000_0010;
        end
    end
    // saturates so a long hold flush never wraps into a short count
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !flushActive) begin
            flushCntReg <= 6'h00;
        end else if (flushCntReg != 6'h3F) begin
            flushCntReg <= flushCntReg + 6'h01;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_port_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_full_off: assert property (wrCtrl0Reg && hwdata[CTRL0_FULL_PD_BIT] |-> ##[1:2] powerOut == 6'h00)
        else $error("full power-down left a domain on");
    a_ref_all: assert property (!powerOut.referenceEnable |-> powerOut == 6'h00)
        else $error("reference off outside full power-down");
    a_main_sleep: assert property (wrSleepReg && hwdata[SLEEP_MAIN0_BIT] |-> ##[1:2] !powerOut.mainConverterEnable[0])
        else $error("main converter did not sleep");
    a_aux_sleep: assert property (wrSleepReg && hwdata[SLEEP_AUX1_BIT] |-> ##[1:2] !powerOut.auxConverterEnable[1])
        else $error("aux converter did not sleep");
    a_flush_zero: assert property (flushActive |-> sampleOut == '0 && sampleOutValid)
        else $error("flush not feeding valid zeros");
    a_flush_len: assert property ($fell(powerOut.digitalEnable) && flushCntReg != 6'h00 |-> flushCntReg >= 6'(FLUSH_CYCLES))
        else $error("engine stopped before flush length");
    a_off_quiet: assert property ($fell(powerOut.digitalEnable) && flushCntReg != 6'h00 |-> !sampleOutValid && sampleOut == '0)
        else $error("engine off still emitting samples");
    a_run_copy: assert property (sampleOutValid && !flushActive |-> sampleOut == $past(sampleIn))
        else $error("run sample not copied from input");
endmodule : dpd_power_ctrl_monitor
bind dpd_power_ctrl dpd_power_ctrl_monitor dpd_power_ctrl_monitor_inst (.clk_sys, .reset_n, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .sampleIn,
    .sampleOut, .sampleOutValid, .powerOut, .flushActive);
`default_nettype wire

// >>> dv/dpd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dpd_host_model
    import dpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic transmit_gate,
    output dpd_sample_t sampleIn,
    output logic sampleInValid
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        transmit_gate = 1'b0;
        sampleIn = '0;
        sampleInValid = 1'b1;
    end
    // Q mirrors I inverted so any corruption or stale zero is visible
    always @(posedge clk_sys) begin
        sampleIn <= '{chanI: sampleIn.chanI + 16'h0001, chanQ: ~(sampleIn.chanI + 16'h0001)};
    end
    task setGate(input logic v);
        @(posedge clk_sys);
        transmit_gate <= v;
    endtask : setGate
    // waits on hready with no cycle count assumed; the bench timeout ends a hang
    task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        logic rdy;
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        hsize <= 3'h2;
        do begin
            @(posedge clk_sys);
            rdy = hreadyout;
        end while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge clk_sys);
            rdy = hreadyout;
            q = hrdata;
        end while (rdy !== 1'b1);
    endtask : xfer
endmodule : dpd_host_model
`default_nettype wire

// >>> dv/dpd_power_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dpd_power_ctrl_tb
    import dpd_pkg::*;
;
    localparam logic [31:0] A_CTRL0 = 32'(REG_CTRL0_IDX) << 2;
    localparam logic [31:0] A_CTRL2 = 32'(REG_CTRL2_IDX) << 2;
    localparam logic [31:0] A_SLEEP = 32'(REG_SLEEP_IDX) << 2;
    logic clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, transmit_gate;
    logic sampleInValid, sampleOutValid, flushActive;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    dpd_sample_t sampleIn, sampleOut;
    dpd_power_t powerOut;
    int errCount = 0;
    int testsRun = 0;
    int cycleCount = 0;
    logic [7:0] sleepTab [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h0F};
    dpd_power_ctrl dpd_power_ctrl_inst (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .transmit_gate,
        .sampleIn, .sampleInValid, .sampleOut, .sampleOutValid, .powerOut, .flushActive);
    dpd_host_model dpd_host_model_inst (.clk_sys, .hreadyout, .hrdata, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .transmit_gate, .sampleIn, .sampleInValid);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    function automatic logic counted(input logic bad);
        testsRun++;
        return bad;
    endfunction : counted
    function automatic logic [5:0] expPower(input logic [7:0] s);
        return {~s[SLEEP_DIG_BIT], 1'b1, ~s[SLEEP_MAIN1_BIT], ~s[SLEEP_MAIN0_BIT],
            ~s[SLEEP_AUX1_BIT], ~s[SLEEP_AUX0_BIT]};
    endfunction : expPower
    task fail(input string m);
        errCount++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail
    task settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle
    task regWrite(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        dpd_host_model_inst.xfer(1'b1, a, d, q);
    endtask : regWrite
    task regRead(input logic [31:0] a, output logic [31:0] q);
        dpd_host_model_inst.xfer(1'b0, a, 32'h0000_0000, q);
    endtask : regRead
    task testReset;
        logic [31:0] q;
        settle(1);
        if (counted(powerOut !== 6'h3F)) fail("power after reset");
        regWrite(32'h0000_0018, 32'hFFFF_FFFF);
        for (int i = 0; i < 4; i++) begin
            regRead(32'(i * 8), q);
            if (counted(q !== 32'h0000_0000)) fail("register not zero");
        end
        $display("test reset done");
    endtask : testReset
    task testFlushRun;
        logic [31:0] q;
        settle(4);
        regRead(32'(REG_STATUS_IDX) << 2, q);
        if (counted(q !== 32'h0000_0026)) fail("status in hold flush");
        if (counted(flushActive !== 1'b1 || sampleOut !== '0 || sampleOutValid !== 1'b1)) fail("hold flush");
        if (counted(powerOut !== 6'h3F)) fail("hold flush power");
        dpd_host_model_inst.setGate(1'b1);
        settle(5);
        if (counted(flushActive !== 1'b0 || sampleOutValid !== 1'b1 || sampleOut.chanQ !== ~sampleOut.chanI)) fail("run");
        $display("test flush run done");
    endtask : testFlushRun
    task testAuto;
        int n;
        regWrite(A_CTRL0, 32'h0000_0008);
        dpd_host_model_inst.setGate(1'b0);
        n = 0;
        while (flushActive !== 1'b1 && n < 10) begin
            settle(1);
            n++;
        end
        n = 0;
        while (powerOut.digitalEnable === 1'b1 && n < 40) begin
            settle(1);
            n++;
        end
        if (counted(n < FLUSH_CYCLES || n > FLUSH_CYCLES + 2)) fail("flush length");
        if (counted(powerOut !== 6'h1F || sampleOutValid !== 1'b0)) fail("auto off");
        dpd_host_model_inst.setGate(1'b1);
        settle(5);
        if (counted(powerOut !== 6'h3F || flushActive !== 1'b0 || sampleOutValid !== 1'b1)) fail("resume");
        regWrite(A_CTRL0, 32'h0000_0000);
        $display("test auto done");
    endtask : testAuto
    task testPolarity;
        regWrite(A_CTRL2, 32'h0000_0002);
        settle(5);
        if (counted(flushActive !== 1'b1)) fail("inverted high gate");
        dpd_host_model_inst.setGate(1'b0);
        settle(5);
        if (counted(flushActive !== 1'b0 || sampleOutValid !== 1'b1)) fail("inverted low gate");
        regWrite(A_CTRL2, 32'h0000_0000);
        dpd_host_model_inst.setGate(1'b1);
        settle(5);
        $display("test polarity done");
    endtask : testPolarity
    task testSleep;
        logic [31:0] q;
        foreach (sleepTab[i]) begin
            regWrite(A_SLEEP, {24'h000000, sleepTab[i]});
            settle(3);
            if (counted(powerOut !== expPower(sleepTab[i]))) fail("sleep power");
            regRead(A_SLEEP, q);
            if (counted(q !== {24'h000000, sleepTab[i]})) fail("sleep readback");
        end
        regWrite(A_SLEEP, 32'h0000_0000);
        $display("test sleep done");
    endtask : testSleep
    task testFull;
        logic [31:0] q;
        regWrite(A_CTRL0, 32'h0000_0010);
        settle(3);
        if (counted(powerOut !== 6'h00)) fail("full power-down");
        regRead(A_CTRL0, q);
        if (counted(q !== 32'h0000_0010)) fail("port dead in power-down");
        regWrite(A_CTRL0, 32'h0000_0000);
        settle(3);
        if (counted(powerOut !== 6'h3F)) fail("wake from power-down");
        $display("test full done");
    endtask : testFull
    task printVerdict;
        $display("comparisons %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : printVerdict
    always @(posedge clk_sys) begin
        cycleCount++;
        if (cycleCount == 5000) begin
            fail("timeout");
            printVerdict();
        end
    end
    initial begin
        reset_n = 1'b0;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        testReset();
        testFlushRun();
        testAuto();
        testPolarity();
        testSleep();
        testFull();
        printVerdict();
    end
endmodule : dpd_power_ctrl_tb
`default_nettype wire
